// ==== pisr_pkg.sv ====
// Notes on behaviour
// - capability bit 7 always reads 1: packet error checking is supported
// - capability bits 6:5 fixed at 01b: highest bus clock is 400 kHz
// - capability bit 4 fixed at 1: alert output and alert response supported
// - capability is unpaged read byte at 0x19 returning 0xB0, low nibble zero
// - revision is unpaged read byte at 0x98 returning constant 0x11
// - part identifier at 0xE7 returns a fixed variant-specific word
// - paged read byte at 0xE8 returns the per-channel factory lot code
// - info status at 0xB6 refreshed after reset, restore-all and bulk read
// - info bit 5 is 0 from reset and after ECC corrections, 1 after a clean result; others reserved
// - scratch words 0xB3 paged and 0xB4 unpaged, default 0x0000, read/write
// - reserved words 0xB0, 0xB2 unpaged, 0xB1 paged, 0xBC paged and volatile
package pisr_pkg;
    localparam logic [7:0]  CMD_CAPABILITY = 8'h19;
    localparam logic [7:0]  CMD_REVISION   = 8'h98;
    localparam logic [7:0]  CMD_TOOL_A     = 8'hB0;
    localparam logic [7:0]  CMD_TOOL_B     = 8'hB1;
    localparam logic [7:0]  CMD_OEM        = 8'hB2;
    localparam logic [7:0]  CMD_SCRATCH_P  = 8'hB3;
    localparam logic [7:0]  CMD_SCRATCH_S  = 8'hB4;
    localparam logic [7:0]  CMD_INFO       = 8'hB6;
    localparam logic [7:0]  CMD_VENDOR     = 8'hBC;
    localparam logic [7:0]  CMD_PART_ID    = 8'hE7;
    localparam logic [7:0]  CMD_LOT        = 8'hE8;

    localparam int          CAP_PEC_POS    = 7;
    localparam int          CAP_SCL_LSB    = 5;
    localparam logic [1:0]  CAP_SCL_400K   = 2'h1;
    localparam int          CAP_ALERT_POS  = 4;
    localparam logic [7:0]  CAP_VALUE      = 8'hB0;
    localparam logic [7:0]  REV_VALUE      = 8'h11;
    localparam int          INFO_ECC_POS   = 5;
    localparam logic [15:0] INFO_ECC_MASK  = 16'h0020;
    localparam logic        INFO_ECC_RESET = 1'h0;
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    localparam logic [7:0]  BYTE_PAD       = 8'h00;
    localparam int          WORD_W         = 16;

    typedef logic [3:0] pisr_idx_t;
    localparam pisr_idx_t   IDX_TOOL_A     = 4'h0;
    localparam pisr_idx_t   IDX_TOOL_B0    = 4'h1;
    localparam pisr_idx_t   IDX_OEM        = 4'h3;
    localparam pisr_idx_t   IDX_SCR_P0     = 4'h4;
    localparam pisr_idx_t   IDX_SCR_S      = 4'h6;
    localparam pisr_idx_t   IDX_VEND0      = 4'h7;
    localparam pisr_idx_t   IDX_LOT0       = 4'h9;
    localparam int          STORE_DEPTH    = 11;
    localparam int          IDX_W          = 4;

    typedef enum logic [2:0] {
        PISR_SRC_NONE  = 3'h0,
        PISR_SRC_CAP   = 3'h1,
        PISR_SRC_REV   = 3'h2,
        PISR_SRC_ID    = 3'h3,
        PISR_SRC_INFO  = 3'h4,
        PISR_SRC_STORE = 3'h5,
        PISR_SRC_LOT   = 3'h6
    } pisr_src_e;

    typedef enum logic [1:0] {
        PISR_ST_IDLE = 2'h0,
        PISR_ST_WAIT = 2'h1
    } pisr_state_e;

    typedef struct packed {
        logic      hit;
        logic      rw;
        logic      ee;
        pisr_src_e src;
        pisr_idx_t idx;
    } pisr_dec_s;
endpackage : pisr_pkg

// ==== pisr_store_if.sv ====
`timescale 1ns/1ns
interface pisr_store_if #(
    parameter int WIDTH = pisr_pkg::WORD_W,
    parameter int IDX_W = pisr_pkg::IDX_W
);
    logic             wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [WIDTH-1:0] wr_data;
    logic [IDX_W-1:0] rd_idx;
    logic [WIDTH-1:0] rd_data;

    modport ctrl  (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
    modport store (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface : pisr_store_if

// ==== pisr_word_store.sv ====
`timescale 1ns/1ns
module pisr_word_store #(
    parameter int WIDTH = pisr_pkg::WORD_W,
    parameter int DEPTH = pisr_pkg::STORE_DEPTH,
    parameter int IDX_W = pisr_pkg::IDX_W
) (
    // clock and reset
    input wire logic   clock,
    input wire logic   rst,
    input wire logic   ce,
    // access port
    pisr_store_if.store bus
);
    logic [WIDTH-1:0] word_q [DEPTH];

    if (WIDTH != pisr_pkg::WORD_W || DEPTH < 1 || DEPTH > (1 << IDX_W))
    begin : g_bad_size
        $error("word store size not supported");
    end

    for (genvar i = 0; i < DEPTH; i++)
    begin : g_word
        // every entry comes up at the scratch default
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
                word_q[i] <= pisr_pkg::WORD_RESET;
            else if (ce && bus.wr_en && bus.wr_idx == IDX_W'(i))
                word_q[i] <= bus.wr_data;
        end
    end

    // out-of-range index reads zero rather than x
    assign bus.rd_data = (int'(bus.rd_idx) < DEPTH) ? word_q[bus.rd_idx] : '0;

    property p_store_hold;
        @(posedge clock) disable iff (rst)
        !(ce && bus.wr_en && bus.wr_idx == bus.rd_idx) |=>
            $stable(bus.rd_data) || $changed(bus.rd_idx);
    endproperty
    a_store_hold: assert property (p_store_hold)
        else $error("store word changed without a write");
endmodule : pisr_word_store

// ==== pisr_regs.sv ====
`timescale 1ns/1ns
module pisr_regs #(
    // arbitrary neutral value, replaced per variant
    parameter logic [15:0] VARIANT_ID = 16'h0A50,
    parameter int          DEPTH      = pisr_pkg::STORE_DEPTH
) (
    // clock, reset, enable
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    // command from transaction engine
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        page_sel,
    // response to transaction engine
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    output logic             rsp_supported,
    output logic             rsp_refused,
    // eeprom controller events
    input  wire logic        ee_restore,
    input  wire logic        ee_bulk_read,
    input  wire logic        ee_ecc_valid,
    input  wire logic        ee_ecc_corrected,
    input  wire logic        ee_load_valid,
    input  wire logic [7:0]  ee_load_code,
    input  wire logic        ee_load_page,
    input  wire logic [15:0] ee_load_data,
    // status
    output logic             refresh_pending
);
    pisr_pkg::pisr_dec_s   dec;
    pisr_pkg::pisr_dec_s   ldec;
    pisr_pkg::pisr_state_e state_q;
    pisr_pkg::pisr_state_e state_d;
    logic                  info_ecc_q;
    logic                  refresh_pending_q;
    logic                  rsp_valid_q;
    logic [15:0]           rsp_data_q;
    logic                  rsp_supported_q;
    logic                  rsp_refused_q;
    logic [15:0]           rd_word;
    logic [7:0]            cap_byte;
    logic [15:0]           info_word;
    logic                  load_hit;
    logic                  host_wr;
    logic                  refresh_evt;

    pisr_store_if st_if ();

    if (DEPTH <= int'(pisr_pkg::IDX_LOT0) + 1)
    begin : g_bad_depth
        $error("store depth too small for the command map");
    end

    function automatic pisr_pkg::pisr_dec_s decode_cmd(input logic [7:0] code,
                                                       input logic       page);
        pisr_pkg::pisr_dec_s d;
        d.hit = 1'b1;
        d.rw  = 1'b0;
        d.ee  = 1'b0;
        d.src = pisr_pkg::PISR_SRC_STORE;
        d.idx = pisr_pkg::IDX_TOOL_A;
        case (code)
            pisr_pkg::CMD_CAPABILITY: d.src = pisr_pkg::PISR_SRC_CAP;
            pisr_pkg::CMD_REVISION:   d.src = pisr_pkg::PISR_SRC_REV;
            pisr_pkg::CMD_PART_ID:    d.src = pisr_pkg::PISR_SRC_ID;
            pisr_pkg::CMD_INFO:       d.src = pisr_pkg::PISR_SRC_INFO;
            pisr_pkg::CMD_LOT:
            begin
                // read-only to the host, loadable from eeprom
                d.src = pisr_pkg::PISR_SRC_LOT;
                d.ee  = 1'b1;
                d.idx = pisr_pkg::pisr_idx_t'(pisr_pkg::IDX_LOT0 + page);
            end
            pisr_pkg::CMD_TOOL_A:
            begin
                d.rw = 1'b1;
                d.ee = 1'b1;
            end
            pisr_pkg::CMD_TOOL_B:
            begin
                d.rw  = 1'b1;
                d.ee  = 1'b1;
                d.idx = pisr_pkg::pisr_idx_t'(pisr_pkg::IDX_TOOL_B0 + page);
            end
            pisr_pkg::CMD_OEM:
            begin
                d.rw  = 1'b1;
                d.ee  = 1'b1;
                d.idx = pisr_pkg::IDX_OEM;
            end
            pisr_pkg::CMD_SCRATCH_P:
            begin
                d.rw  = 1'b1;
                d.ee  = 1'b1;
                d.idx = pisr_pkg::pisr_idx_t'(pisr_pkg::IDX_SCR_P0 + page);
            end
            pisr_pkg::CMD_SCRATCH_S:
            begin
                d.rw  = 1'b1;
                d.ee  = 1'b1;
                d.idx = pisr_pkg::IDX_SCR_S;
            end
            pisr_pkg::CMD_VENDOR:
            begin
                // volatile: eeprom loads never reach it
                d.rw  = 1'b1;
                d.idx = pisr_pkg::pisr_idx_t'(pisr_pkg::IDX_VEND0 + page);
            end
            default:
            begin
                d.hit = 1'b0;
                d.src = pisr_pkg::PISR_SRC_NONE;
            end
        endcase
        return d;
    endfunction : decode_cmd

    assign dec         = decode_cmd(cmd_code, page_sel);
    assign ldec        = decode_cmd(ee_load_code, ee_load_page);
    assign refresh_evt = ee_restore || ee_bulk_read;

    // eeprom loads take the single write port; a host write in that cycle is refused
    assign load_hit = ee_load_valid && ldec.ee;
    assign host_wr  = cmd_valid && cmd_write && dec.rw && !load_hit;

    assign st_if.wr_en   = load_hit || host_wr;
    assign st_if.wr_idx  = load_hit ? ldec.idx : dec.idx;
    assign st_if.wr_data = load_hit ? ee_load_data : cmd_wdata;
    assign st_if.rd_idx  = dec.idx;

    pisr_word_store #(
        .WIDTH (pisr_pkg::WORD_W),
        .DEPTH (DEPTH),
        .IDX_W (pisr_pkg::IDX_W)
    ) u_store (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .bus   (st_if.store)
    );

    always_comb
    begin
        cap_byte                                     = '0;
        cap_byte[pisr_pkg::CAP_PEC_POS]              = 1'b1;
        cap_byte[pisr_pkg::CAP_SCL_LSB+1:pisr_pkg::CAP_SCL_LSB] = pisr_pkg::CAP_SCL_400K;
        cap_byte[pisr_pkg::CAP_ALERT_POS]            = 1'b1;
        info_word                                    = '0;
        info_word[pisr_pkg::INFO_ECC_POS]            = info_ecc_q;
    end

    always_comb
    begin
        unique case (dec.src)
            pisr_pkg::PISR_SRC_CAP:   rd_word = {pisr_pkg::BYTE_PAD, cap_byte};
            pisr_pkg::PISR_SRC_REV:   rd_word = {pisr_pkg::BYTE_PAD, pisr_pkg::REV_VALUE};
            pisr_pkg::PISR_SRC_ID:    rd_word = VARIANT_ID;
            pisr_pkg::PISR_SRC_INFO:  rd_word = info_word;
            pisr_pkg::PISR_SRC_LOT:   rd_word = {pisr_pkg::BYTE_PAD, st_if.rd_data[7:0]};
            pisr_pkg::PISR_SRC_STORE: rd_word = st_if.rd_data;
            default:                  rd_word = pisr_pkg::WORD_RESET;
        endcase
    end

    // one-cycle answer; writes answer zero data
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rsp_valid_q     <= 1'b0;
            rsp_data_q      <= pisr_pkg::WORD_RESET;
            rsp_supported_q <= 1'b0;
            rsp_refused_q   <= 1'b0;
        end
        else if (ce)
        begin
            rsp_valid_q <= cmd_valid;
            if (cmd_valid)
            begin
                rsp_supported_q <= dec.hit;
                rsp_refused_q   <= cmd_write && !host_wr;
                rsp_data_q      <= cmd_write ? pisr_pkg::WORD_RESET : rd_word;
            end
        end
    end

    // refresh pending from reset until the eeprom reports its ecc result
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            pisr_pkg::PISR_ST_IDLE: if (refresh_evt) state_d = pisr_pkg::PISR_ST_WAIT;
            pisr_pkg::PISR_ST_WAIT: if (ee_ecc_valid && !refresh_evt)
                                        state_d = pisr_pkg::PISR_ST_IDLE;
            default:                state_d = pisr_pkg::PISR_ST_WAIT;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_q           <= pisr_pkg::PISR_ST_WAIT;
            refresh_pending_q <= 1'b1;
        end
        else if (ce)
        begin
            state_q           <= state_d;
            refresh_pending_q <= (state_d == pisr_pkg::PISR_ST_WAIT);
        end
    end

    // a new event in the same cycle as the result restarts the wait
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            info_ecc_q <= pisr_pkg::INFO_ECC_RESET;
        else if (ce && state_q == pisr_pkg::PISR_ST_WAIT && ee_ecc_valid && !refresh_evt)
            info_ecc_q <= !ee_ecc_corrected;
    end

    assign rsp_valid       = rsp_valid_q;
    assign rsp_data        = rsp_data_q;
    assign rsp_supported   = rsp_supported_q;
    assign rsp_refused     = rsp_refused_q;
    assign refresh_pending = refresh_pending_q;

    property p_cap_pec;
        @(posedge clock) disable iff (rst)
        ce && cmd_valid && !cmd_write && cmd_code == pisr_pkg::CMD_CAPABILITY
            |=> rsp_valid_q && rsp_data_q[pisr_pkg::CAP_PEC_POS];
    endproperty
    a_cap_pec: assert property (p_cap_pec)
        else $error("capability pec bit not set");

    property p_cap_scl;
        @(posedge clock) disable iff (rst)
        ce && cmd_valid && !cmd_write && cmd_code == pisr_pkg::CMD_CAPABILITY
            |=> rsp_data_q[pisr_pkg::CAP_SCL_LSB+1:pisr_pkg::CAP_SCL_LSB]
                == pisr_pkg::CAP_SCL_400K;
    endproperty
    a_cap_scl: assert property (p_cap_scl)
        else $error("capability bus speed field wrong");

    property p_cap_alert;
        @(posedge clock) disable iff (rst)
        ce && cmd_valid && !cmd_write && cmd_code == pisr_pkg::CMD_CAPABILITY
            |=> rsp_data_q[pisr_pkg::CAP_ALERT_POS] && rsp_supported_q;
    endproperty
    a_cap_alert: assert property (p_cap_alert)
        else $error("capability alert bit not set");

    property p_cap_value;
        @(posedge clock) disable iff (rst)
        ce && cmd_valid && !cmd_write && cmd_code == pisr_pkg::CMD_CAPABILITY
            |=> rsp_data_q == {pisr_pkg::BYTE_PAD, pisr_pkg::CAP_VALUE};
    endproperty
    a_cap_value: assert property (p_cap_value)
        else $error("capability byte not 0xB0");

    property p_revision;
        @(posedge clock) disable iff (rst)
        ce && cmd_valid && !cmd_write && cmd_code == pisr_pkg::CMD_REVISION
            |=> rsp_supported_q && rsp_data_q == {pisr_pkg::BYTE_PAD, pisr_pkg::REV_VALUE};
    endproperty
    a_revision: assert property (p_revision)
        else $error("revision byte wrong");

    property p_part_id;
        @(posedge clock) disable iff (rst)
        ce && cmd_valid && cmd_code == pisr_pkg::CMD_PART_ID
            |=> rsp_refused_q == $past(cmd_write)
                && ($past(cmd_write) || rsp_data_q == VARIANT_ID);
    endproperty
    a_part_id: assert property (p_part_id)
        else $error("part identifier wrong or writable");

    property p_lot_load;
        @(posedge clock) disable iff (rst)
        (ce && ee_load_valid && ee_load_code == pisr_pkg::CMD_LOT) ##1
        (ce && cmd_valid && !cmd_write && cmd_code == pisr_pkg::CMD_LOT
            && page_sel == $past(ee_load_page) && !ee_load_valid)
            |=> rsp_data_q == {pisr_pkg::BYTE_PAD, $past(ee_load_data[7:0], 2)};
    endproperty
    a_lot_load: assert property (p_lot_load)
        else $error("lot code not returned for its page");

    property p_refresh_idle;
        @(posedge clock) disable iff (rst)
        ce && state_q == pisr_pkg::PISR_ST_IDLE && !refresh_evt
            |=> state_q == pisr_pkg::PISR_ST_IDLE && $stable(info_ecc_q);
    endproperty
    a_refresh_idle: assert property (p_refresh_idle)
        else $error("ecc result taken without a pending refresh");

    property p_refresh_start;
        @(posedge clock) disable iff (rst)
        ce && refresh_evt |=> refresh_pending_q && state_q == pisr_pkg::PISR_ST_WAIT;
    endproperty
    a_refresh_start: assert property (p_refresh_start)
        else $error("refresh event did not start a refresh");

    property p_info_read;
        @(posedge clock) disable iff (rst)
        ce && cmd_valid && !cmd_write && cmd_code == pisr_pkg::CMD_INFO
            |=> (rsp_data_q & ~pisr_pkg::INFO_ECC_MASK) == pisr_pkg::WORD_RESET
                && rsp_data_q[pisr_pkg::INFO_ECC_POS] == $past(info_ecc_q);
    endproperty
    a_info_read: assert property (p_info_read)
        else $error("info status word wrong");

    property p_ecc_capture;
        @(posedge clock) disable iff (rst)
        ce && state_q == pisr_pkg::PISR_ST_WAIT && ee_ecc_valid && !refresh_evt
            |=> info_ecc_q == !$past(ee_ecc_corrected) && !refresh_pending_q;
    endproperty
    a_ecc_capture: assert property (p_ecc_capture)
        else $error("ecc status not captured");

    property p_scratch_rw;
        @(posedge clock) disable iff (rst)
        (ce && cmd_valid && cmd_write && cmd_code == pisr_pkg::CMD_SCRATCH_P && !ee_load_valid)
        ##1 (ce && cmd_valid && !cmd_write && cmd_code == pisr_pkg::CMD_SCRATCH_P
            && page_sel == $past(page_sel))
            |=> rsp_data_q == $past(cmd_wdata, 2);
    endproperty
    a_scratch_rw: assert property (p_scratch_rw)
        else $error("paged scratch word did not keep written value");

    property p_vendor_rw;
        @(posedge clock) disable iff (rst)
        (ce && cmd_valid && cmd_write && cmd_code == pisr_pkg::CMD_VENDOR && !ee_load_valid)
        ##1 (ce && cmd_valid && !cmd_write && cmd_code == pisr_pkg::CMD_VENDOR
            && page_sel == $past(page_sel))
            |=> rsp_data_q == $past(cmd_wdata, 2) && !rsp_refused_q;
    endproperty
    a_vendor_rw: assert property (p_vendor_rw)
        else $error("volatile reserved word did not keep written value");

    property p_ro_write;
        @(posedge clock) disable iff (rst)
        ce && cmd_valid && cmd_write && !dec.rw |-> !st_if.wr_en || load_hit ##1 rsp_refused_q;
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("write to read-only code was not refused");
endmodule : pisr_regs

// ==== pisr_host_model.sv ====
`timescale 1ns/1ns
module pisr_host_model (
    // clock
    input  wire logic        clock,
    // command lines
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    output logic             page_sel,
    // answer lines
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_data,
    input  wire logic        rsp_supported,
    input  wire logic        rsp_refused
);
    logic        got_vld;
    logic [15:0] got_data;
    logic        got_sup;
    logic        got_ref;

    initial
    begin
        cmd_valid = 1'h0;
        cmd_write = 1'h0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
        page_sel  = 1'h0;
    end

    // entered just after an edge; hold chains the next command back to back
    task automatic xfer(input logic wr, input logic [7:0] code, input logic pg,
                        input logic [15:0] wd, input logic hold);
        cmd_valid = 1'h1;
        cmd_write = wr;
        cmd_code  = code;
        cmd_wdata = wd;
        page_sel  = pg;
        @(posedge clock);
        #1;
        // answer registered on the taking edge, sampled 1 ns after it
        got_vld  = rsp_valid;
        got_data = rsp_data;
        got_sup  = rsp_supported;
        got_ref  = rsp_refused;
        if (!hold)
        begin
            // idle lines inverted so stale values never look valid
            cmd_valid = 1'h0;
            cmd_write = ~wr;
            cmd_code  = ~code;
            cmd_wdata = ~wd;
            page_sel  = ~pg;
            @(posedge clock);
            #1;
        end
    endtask : xfer
endmodule : pisr_host_model

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
    // arbitrary variant code
    localparam logic [15:0] ID_VAL = 16'h0A57;
    logic        clock;
    logic        rst;
    logic        ce;
    logic        cmd_valid;
    logic        cmd_write;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata;
    logic        page_sel;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        rsp_supported;
    logic        rsp_refused;
    logic        ee_restore;
    logic        ee_bulk_read;
    logic        ee_ecc_valid;
    logic        ee_ecc_corrected;
    logic        ee_load_valid;
    logic [7:0]  ee_load_code;
    logic        ee_load_page;
    logic [15:0] ee_load_data;
    logic        refresh_pending;
    int          err_count;
    int          n_compared;
    int          cycles;

    pisr_regs #(.VARIANT_ID(ID_VAL)) DUT (.clock, .rst, .ce, .cmd_valid, .cmd_write,
        .cmd_code, .cmd_wdata, .page_sel, .rsp_valid, .rsp_data, .rsp_supported,
        .rsp_refused, .ee_restore, .ee_bulk_read, .ee_ecc_valid, .ee_ecc_corrected,
        .ee_load_valid, .ee_load_code, .ee_load_page, .ee_load_data, .refresh_pending);

    pisr_host_model host (.clock, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
        .page_sel, .rsp_valid, .rsp_data, .rsp_supported, .rsp_refused);

    initial
    begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    // whole run needs under two hundred cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            err_count++;
            results;
        end
    end

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: flag %h, expected %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic rd(input logic [7:0] code, input logic pg, input logic [15:0] exp);
        host.xfer(1'h0, code, pg, 16'h0000, 1'h0);
        chk_bit(host.got_vld, 1'h1);
        chk_bit(host.got_sup, 1'h1);
        chk_word(host.got_data, exp);
    endtask : rd

    task automatic wr(input logic [7:0] code, input logic pg, input logic [15:0] d,
                      input logic refused, input logic hold);
        host.xfer(1'h1, code, pg, d, hold);
        chk_bit(host.got_vld, 1'h1);
        chk_bit(host.got_ref, refused);
    endtask : wr

    // ev = restore, bulk read, ecc valid, corrected; a nonzero code loads
    task automatic ee(input logic [3:0] ev, input logic [7:0] code, input logic pg,
                      input logic [15:0] d);
        {ee_restore, ee_bulk_read, ee_ecc_valid, ee_ecc_corrected} = ev;
        ee_load_valid = (code != 8'h00);
        ee_load_code  = code;
        ee_load_page  = pg;
        ee_load_data  = d;
        @(posedge clock);
        #1;
        {ee_restore, ee_bulk_read, ee_ecc_valid, ee_load_valid} = 4'h0;
        @(posedge clock);
        #1;
    endtask : ee

    task automatic t_reset;
        logic [7:0] c [6] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hBC};
        chk_bit(refresh_pending, 1'h1);
        for (int i = 0; i < 6; i++)
        begin
            rd(c[i], 1'h0, 16'h0000);
            rd(c[i], 1'h1, 16'h0000);
        end
        $display("test reset values done");
    endtask : t_reset

    task automatic t_ident;
        rd(8'h19, 1'h0, 16'h00B0);
        rd(8'h98, 1'h0, 16'h0011);
        rd(8'hE7, 1'h1, ID_VAL);
        $display("test identification done");
    endtask : t_ident

    task automatic t_scratch;
        logic [7:0] c [9] = '{8'hB3, 8'hB3, 8'hB4, 8'hB0, 8'hB1, 8'hB1, 8'hB2, 8'hBC, 8'hBC};
        logic       p [9] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
        for (int i = 0; i < 9; i++)
        begin
            wr(c[i], p[i], 16'(i + 1) * 16'h1111, 1'h0, 1'h1);
            rd(c[i], p[i], 16'(i + 1) * 16'h1111);
        end
        // second pass catches one page overwriting the other
        for (int i = 0; i < 9; i++)
        begin
            rd(c[i], p[i], 16'(i + 1) * 16'h1111);
        end
        rd(8'hB4, 1'h1, 16'h3333);
        $display("test scratch words done");
    endtask : t_scratch

    task automatic t_info;
        ee(4'h2, 8'h00, 1'h0, 16'h0000);
        chk_bit(refresh_pending, 1'h0);
        rd(8'hB6, 1'h0, 16'h0020);
        ee(4'h8, 8'h00, 1'h0, 16'h0000);
        chk_bit(refresh_pending, 1'h1);
        ee(4'h3, 8'h00, 1'h0, 16'h0000);
        rd(8'hB6, 1'h0, 16'h0000);
        ee(4'h4, 8'h00, 1'h0, 16'h0000);
        chk_bit(refresh_pending, 1'h1);
        // event and result in one cycle: the event wins
        ee(4'hA, 8'h00, 1'h0, 16'h0000);
        chk_bit(refresh_pending, 1'h1);
        rd(8'hB6, 1'h0, 16'h0000);
        ee(4'h2, 8'h00, 1'h0, 16'h0000);
        rd(8'hB6, 1'h0, 16'h0020);
        ee(4'h3, 8'h00, 1'h0, 16'h0000);
        rd(8'hB6, 1'h0, 16'h0020);
        $display("test info status done");
    endtask : t_info

    task automatic t_ro;
        logic [7:0] c [6] = '{8'h19, 8'h98, 8'hB6, 8'hE7, 8'hE8, 8'hB5};
        for (int i = 0; i < 6; i++)
        begin
            wr(c[i], 1'h0, 16'hFFFF, 1'h1, 1'h0);
        end
        chk_bit(host.got_sup, 1'h0);
        t_ident;
        rd(8'hB6, 1'h0, 16'h0020);
        rd(8'hE8, 1'h0, 16'h0000);
        $display("test read-only writes done");
    endtask : t_ro

    task automatic t_ce;
        ce = 1'h0;
        host.xfer(1'h1, 8'hB4, 1'h0, 16'hABCD, 1'h0);
        chk_bit(host.got_vld, 1'h0);
        chk_bit(refresh_pending, 1'h0);
        ce = 1'h1;
        rd(8'hB4, 1'h0, 16'h3333);
        $display("test clock enable done");
    endtask : t_ce

    task automatic t_lot;
        ee(4'h0, 8'hE8, 1'h0, 16'h12A5);
        ee(4'h0, 8'hBC, 1'h0, 16'h1234);
        // page 1 lot read the cycle after its load
        {ee_load_valid, ee_load_code} = {1'h1, 8'hE8};
        {ee_load_page, ee_load_data}  = {1'h1, 16'h345A};
        @(posedge clock);
        #1;
        ee_load_valid = 1'h0;
        rd(8'hE8, 1'h1, 16'h005A);
        rd(8'hE8, 1'h0, 16'h00A5);
        rd(8'hBC, 1'h0, 16'h8888);
        // host write lost to a load in the same cycle
        {ee_load_valid, ee_load_code, ee_load_data} = {1'h1, 8'hB4, 16'h5A5A};
        wr(8'hB2, 1'h0, 16'hFFFF, 1'h1, 1'h1);
        ee_load_valid = 1'h0;
        rd(8'hB2, 1'h0, 16'h7777);
        rd(8'hB4, 1'h0, 16'h5A5A);
        $display("test lot codes done");
    endtask : t_lot

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    initial
    begin
        err_count  = 0;
        n_compared = 0;
        rst        = 1'h1;
        ce         = 1'h1;
        {ee_restore, ee_bulk_read, ee_ecc_valid, ee_ecc_corrected} = 4'h0;
        ee_load_valid = 1'h0;
        ee_load_code  = 8'h00;
        ee_load_page  = 1'h0;
        ee_load_data  = 16'h0000;
        repeat (20) @(posedge clock);
        #1;
        rst = 1'h0;
        t_reset;
        t_ident;
        t_scratch;
        t_info;
        t_ro;
        t_ce;
        t_lot;
        results;
    end
endmodule : tb
